/* File: mss_defs.svh */
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
// instruction word fields (bit 0 is the msb)
`define MSS_IR_W        12
`define MSS_N_W         4
`define MSS_GRP_MISC    7'h00
`define MSS_OP_ROL      7'h05
`define MSS_OP_ROR      7'h06
`define MSS_OP_SCR      7'h07
`define MSS_OP_SXL      7'h08
`define MSS_OP_SNS      7'h09
// miscellaneous group codes in N
`define MSS_N_HALT      4'h0
`define MSS_N_MODE      4'h2
`define MSS_N_FUNCS     4'h4
`define MSS_N_MQAC      4'h5
`define MSS_N_NOSAVE    4'h6
`define MSS_N_CLEAR     4'h9
`define MSS_N_ATR       4'hC
`define MSS_N_RTA       4'hD
`define MSS_N_COM       4'hF
// sense-skip codes in N
`define MSS_N_AZE       4'h8
`define MSS_N_APO       4'h9
`define MSS_N_LZE       4'hA
`define MSS_N_FLO       4'hC
`define MSS_N_QLZ       4'hD
`define MSS_N_SKP       4'hE
`define MSS_N_SNS_MAX   4'h5
// timing
`define MSS_CLK_NS      25
`define MSS_PAUSE_NS    50
`define MSS_PAUSE_CYC   ((`MSS_PAUSE_NS + `MSS_CLK_NS - 1) / `MSS_CLK_NS)
// bus map (word registers)
`define MSS_A_CTRL      32'h0000_0000
`define MSS_A_IR        32'h0000_0004
`define MSS_A_ACC       32'h0000_0008
`define MSS_A_MQ        32'h0000_000C
`define MSS_A_STAT      32'h0000_0010
`define MSS_A_XL        32'h0000_0014
`endif

/* File: mss_pkg.sv */
package mss_pkg;
  typedef enum logic [2:0] {MSS_IDLE, MSS_TP1, MSS_TP4, MSS_PAUSE, MSS_TP5} mss_tstate_t;
  typedef struct packed {
    logic       link;
    logic [11:0] acc;
    logic [11:0] mq;
  } mss_regs_t;
  typedef struct packed {
    logic       instr_trap;
    logic       tape_trap;
    logic       half_size;
    logic       fast_sample;
    logic       tty_int_off;
  } mss_funcs_t;
endpackage : mss_pkg

/* File: mss_shift.sv */
`timescale 1ns/1ps
`default_nettype none
// one place of rotate or scale on link, acc and mq (acc[11] is msb bit 0)
module mss_shift (
  // operation select
  input  wire logic              is_ror_in,
  input  wire logic              is_scr_in,
  input  wire logic              is_rol_in,
  input  wire logic              ibit_in,
  // data
  input  wire mss_pkg::mss_regs_t d_in,
  output var  mss_pkg::mss_regs_t q_out
);
  import mss_pkg::*;
  // bit 0 of the machine is index 11 here
  always_comb begin
    q_out = d_in;
    if (is_ror_in) begin
      // acc and mq as one 24 place loop, link joins when I is set
      q_out.acc = {(ibit_in ? d_in.link : d_in.mq[0]), d_in.acc[11:1]};
      q_out.mq  = {d_in.acc[0], d_in.mq[11:1]};
      if (ibit_in) q_out.link = d_in.mq[0];
    end else if (is_scr_in) begin
      // sign held, acc low bit into mq
      q_out.acc = {d_in.acc[11], d_in.acc[11:1]};
      q_out.mq  = {d_in.acc[0], d_in.mq[11:1]};
      if (ibit_in) q_out.link = d_in.acc[0];
    end else if (is_rol_in) begin
      q_out.acc = {d_in.acc[10:0], (ibit_in ? d_in.link : d_in.acc[11])};
      if (ibit_in) q_out.link = d_in.acc[11];
    end
  end
endmodule : mss_shift
`default_nettype wire

/* File: mss_exec.sv */
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.svh"
// Behaviour
// - ir bits 0-6 zero selects misc group
// - halt clears run at pulse five
// - mode switch toggles mode at pulse one
// - set funcs: acc 2,3 set traps
// - acc 4-6 set options, 7 presets io
// - read funcs copies flags, other bits zero
// - mq shifted right one into acc
// - n six clears return save flag
// - clear acc, link, mq together
// - acc 6-11 into relays at five
// - relays into acc 6-11 at five
// - acc replaced by ones complement
// - zero shift count does nothing
// - sync at four, repeat after pause
// - rotate right acc-mq, link if I
// - scale right holds sign, link option
// - rotate left acc, link if I
// - skip on condition, bit 07 inverts
// - external level skip selected by n
// - sense switch n, 0456 always true
// - 0451 acc positive, 0450 acc zero
// - link zero, overflow, mq low zero
// - repeat released, last count ends state five
module mss_exec (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // console pins
  input  wire logic [5:0]  sense_sw_in,
  input  wire logic [15:0] ext_level_in,
  input  wire logic        overflow_in,
  // machine state out
  output logic             run_out,
  output logic             mode_out,
  output logic             skip_out,
  output logic             save_pc_out,
  output logic             io_preset_out,
  output logic      [5:0]  relay_out
);
  import mss_pkg::*;

  // synchronisers for pins
  logic [5:0]  sns_s1_r, sns_s2_r;
  logic [15:0] xl_s1_r, xl_s2_r;
  logic        flo_s1_r, flo_s2_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sns_s1_r <= 6'h0_0; sns_s2_r <= 6'h0_0;
      xl_s1_r  <= 16'h0000; xl_s2_r <= 16'h0000;
      flo_s1_r <= 1'b0; flo_s2_r <= 1'b0;
    end else begin
      sns_s1_r <= sense_sw_in; sns_s2_r <= sns_s1_r;
      xl_s1_r  <= ext_level_in; xl_s2_r <= xl_s1_r;
      flo_s1_r <= overflow_in; flo_s2_r <= flo_s1_r;
    end
  end

  // architectural state
  mss_tstate_t ts_r, ts_nxt;
  mss_regs_t   regs_r, regs_nxt, shifted;
  mss_funcs_t  funcs_r, funcs_nxt;
  logic [11:0] ir_r, ir_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [1:0]  pause_r, pause_nxt;
  logic        sync_r, sync_nxt, rep_r, rep_nxt;
  logic        run_r, run_nxt, mode_r, mode_nxt, skip_r, skip_nxt;
  logic        save_r, save_nxt, pre_r, pre_nxt;
  logic [5:0]  relay_r, relay_nxt;
  logic        busy_r;

  // ahb-lite address phase capture
  logic        ap_wr_r;
  logic [31:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic        go_r;

  // decode of the latched word (machine bit 0 = ir[11])
  logic [6:0] opc;
  logic [3:0] n_fld;
  logic       ibit, is_misc, is_ror, is_scr, is_rol, is_sxl, is_sns, cond;
  assign opc     = ir_r[11:5];
  assign ibit    = ir_r[4];
  assign n_fld   = ir_r[3:0];
  // the opcode field is machine bits 0-6, the i bit sits just below it
  assign is_misc = (opc == `MSS_GRP_MISC);
  assign is_ror  = (opc == `MSS_OP_ROR);
  assign is_scr  = (opc == `MSS_OP_SCR);
  assign is_rol  = (opc == `MSS_OP_ROL);
  assign is_sxl  = (opc == `MSS_OP_SXL);
  assign is_sns  = (opc == `MSS_OP_SNS);

  // one place of shift for the repeat loop
  mss_shift u_shift (
    .is_ror_in (is_ror),
    .is_scr_in (is_scr),
    .is_rol_in (is_rol),
    .ibit_in   (ibit),
    .d_in      (regs_r),
    .q_out     (shifted)
  );

  // skip condition, before sense inversion
  always_comb begin
    cond = 1'b0;
    if (is_sxl) begin
      cond = xl_s2_r[n_fld];
    end else if (is_sns) begin
      if (n_fld <= `MSS_N_SNS_MAX) cond = sns_s2_r[3'(n_fld)];
      else if (n_fld == `MSS_N_SKP) cond = 1'b1;
      else if (n_fld == `MSS_N_APO) cond = !regs_r.acc[11];
      else if (n_fld == `MSS_N_AZE)
        cond = (regs_r.acc == 12'h000) || (regs_r.acc == 12'hFFF);
      else if (n_fld == `MSS_N_LZE) cond = !regs_r.link;
      else if (n_fld == `MSS_N_FLO) cond = flo_s2_r;
      else if (n_fld == `MSS_N_QLZ) cond = !regs_r.mq[0];
    end
  end

  // time state sequencer and execute effects
  always_comb begin
    ts_nxt = ts_r; regs_nxt = regs_r; funcs_nxt = funcs_r; ir_nxt = ir_r;
    cnt_nxt = cnt_r; pause_nxt = pause_r; sync_nxt = sync_r; rep_nxt = rep_r;
    run_nxt = run_r; mode_nxt = mode_r; skip_nxt = skip_r; save_nxt = save_r;
    pre_nxt = 1'b0; relay_nxt = relay_r;
    case (ts_r)
      MSS_IDLE: begin
        if (go_r) begin
          ts_nxt = MSS_TP1; skip_nxt = 1'b0;
        end
      end
      MSS_TP1: begin
        if (is_misc && n_fld == `MSS_N_MODE) mode_nxt = !mode_r;
        ts_nxt = MSS_TP4;
      end
      MSS_TP4: begin
        cnt_nxt = n_fld;
        if ((is_ror || is_scr || is_rol) && n_fld != 4'h0) begin
          sync_nxt  = 1'b1;
          pause_nxt = 2'(`MSS_PAUSE_CYC);
          ts_nxt    = MSS_PAUSE;
        end else begin
          ts_nxt = MSS_TP5; // zero count falls straight through
        end
      end
      MSS_PAUSE: begin
        // pause pulse after pulse four arms the repeat
        if (pause_r > 2'd1) pause_nxt = pause_r - 2'd1;
        else begin
          rep_nxt = sync_r;
          ts_nxt  = MSS_TP5;
        end
      end
      MSS_TP5: begin
        if (rep_r) begin
          // one place per repeated state five
          regs_nxt = shifted;
          cnt_nxt  = cnt_r - 4'd1;
          if (cnt_r == 4'd1) begin
            sync_nxt = 1'b0;
            rep_nxt  = 1'b0;
            ts_nxt   = MSS_IDLE;
          end
        end else begin
          ts_nxt = MSS_IDLE;
          if (is_misc) begin
            case (n_fld)
              `MSS_N_HALT: run_nxt = 1'b0;
              `MSS_N_FUNCS: begin
                if (!ibit) begin
                  funcs_nxt.instr_trap  = funcs_r.instr_trap  | regs_r.acc[9];
                  funcs_nxt.tape_trap   = funcs_r.tape_trap   | regs_r.acc[8];
                  funcs_nxt.half_size   = regs_r.acc[7];
                  funcs_nxt.fast_sample = regs_r.acc[6];
                  funcs_nxt.tty_int_off = regs_r.acc[5];
                  pre_nxt = regs_r.acc[4];
                end else begin
                  regs_nxt.acc = {2'b00, funcs_r, 5'b0_0000};
                end
              end
              `MSS_N_MQAC:   regs_nxt.acc = {1'b0, regs_r.mq[11:1]};
              `MSS_N_NOSAVE: save_nxt = 1'b0;
              `MSS_N_CLEAR: begin
                regs_nxt = '0;
              end
              `MSS_N_ATR:    relay_nxt = regs_r.acc[5:0];
              `MSS_N_RTA:    regs_nxt.acc[5:0] = relay_r;
              `MSS_N_COM:    regs_nxt.acc = ~regs_r.acc;
              default: ;
            endcase
          end else if (is_sxl || is_sns) begin
            skip_nxt = cond ^ ibit;
          end
        end
      end
      default: ts_nxt = MSS_IDLE;
    endcase
    // io preset wipes the device flags
    if (pre_r) begin
      funcs_nxt = '0;
    end
    // bus writes load machine words while idle
    if (ap_wr_r && ts_r == MSS_IDLE) begin
      if (ap_addr_r == `MSS_A_IR) ir_nxt = hwdata_in[11:0];
      else if (ap_addr_r == `MSS_A_ACC) regs_nxt.acc = hwdata_in[11:0];
      else if (ap_addr_r == `MSS_A_MQ) regs_nxt.mq = hwdata_in[11:0];
      else if (ap_addr_r == `MSS_A_CTRL) begin
        run_nxt  = hwdata_in[0];
        mode_nxt = hwdata_in[1];
        save_nxt = hwdata_in[2];
        regs_nxt.link = hwdata_in[3];
      end
    end
  end

  assign busy_r = (ts_r != MSS_IDLE);

  // state registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ts_r <= MSS_IDLE; regs_r <= '0; funcs_r <= '0; ir_r <= 12'h000;
      cnt_r <= 4'h0; pause_r <= 2'h0; sync_r <= 1'b0; rep_r <= 1'b0;
      run_r <= 1'b0; mode_r <= 1'b0; skip_r <= 1'b0; save_r <= 1'b0;
      pre_r <= 1'b0; relay_r <= 6'h00;
    end else begin
      ts_r <= ts_nxt; regs_r <= regs_nxt; funcs_r <= funcs_nxt; ir_r <= ir_nxt;
      cnt_r <= cnt_nxt; pause_r <= pause_nxt; sync_r <= sync_nxt; rep_r <= rep_nxt;
      run_r <= run_nxt; mode_r <= mode_nxt; skip_r <= skip_nxt; save_r <= save_nxt;
      pre_r <= pre_nxt; relay_r <= relay_nxt;
    end
  end

  // ahb-lite: writes land in the data phase; reads answered one cycle later
  logic        ap_wr_nxt, ap_rd_nxt, go_nxt;
  logic [31:0] ap_addr_nxt, hrdata_nxt;
  logic        acc_ok;
  always_comb begin
    acc_ok      = hsel_in && hready_in && htrans_in[1];
    ap_wr_nxt   = acc_ok && hwrite_in;
    ap_rd_nxt   = acc_ok && !hwrite_in;
    ap_addr_nxt = acc_ok ? haddr_in : ap_addr_r;
    // a halted machine takes no start
    go_nxt      = ap_wr_r && ap_addr_r == `MSS_A_STAT && hwdata_in[0] && !busy_r && run_r;
    hrdata_nxt  = hrdata_r;
    if (ap_rd_nxt) begin
      // unmapped reads return zero
      if (haddr_in == `MSS_A_CTRL)
        hrdata_nxt = {28'h000_0000, regs_r.link, save_r, mode_r, run_r};
      else if (haddr_in == `MSS_A_IR)  hrdata_nxt = {20'h0_0000, ir_r};
      else if (haddr_in == `MSS_A_ACC) hrdata_nxt = {20'h0_0000, regs_r.acc};
      else if (haddr_in == `MSS_A_MQ)  hrdata_nxt = {20'h0_0000, regs_r.mq};
      else if (haddr_in == `MSS_A_STAT)
        hrdata_nxt = {18'h0_0000, relay_r, funcs_r, skip_r, busy_r, 1'b0};
      else hrdata_nxt = 32'h0000_0000;
    end
  end

  // bus registers (size ignored: whole words only)
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ap_wr_r <= 1'b0; ap_addr_r <= 32'h0000_0000;
      hrdata_r <= 32'h0000_0000; go_r <= 1'b0;
    end else begin
      ap_wr_r <= ap_wr_nxt; ap_addr_r <= ap_addr_nxt;
      hrdata_r <= hrdata_nxt; go_r <= go_nxt;
    end
  end

  // outputs straight from flops, except hreadyout and hresp, which are tied to constants
  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign run_out       = run_r;
  assign mode_out      = mode_r;
  assign skip_out      = skip_r;
  assign save_pc_out   = save_r;
  assign io_preset_out = pre_r;
  assign relay_out     = relay_r;
endmodule : mss_exec
`default_nettype wire

/* File: mss_exec_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mss_exec_chk (
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // bus side
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // machine state
  input wire logic        run_out,
  input wire logic        mode_out,
  input wire logic        skip_out,
  input wire logic        save_pc_out,
  input wire logic        io_preset_out,
  input wire logic [5:0]  relay_out
);
  logic        wr_q;
  logic [7:0]  addr_q;
  logic [11:0] ir_r;
  logic [1:0]  ctl_d;
  // shadow of bus writes; ctl_d spans two cycles to allow a late update
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
      ir_r   <= 12'h000;
      ctl_d  <= 2'h0;
    end else begin
      wr_q   <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      addr_q <= haddr_in[7:0];
      ctl_d  <= {ctl_d[0], wr_q && addr_q == 8'h00};
      if (wr_q && addr_q == 8'h04)
        ir_r <= hwdata_in[11:0];
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // start write seen in its data phase
  sequence s_go;
    wr_q && addr_q == 8'h10 && hwdata_in[0];
  endsequence
  a_ready_high: assert property (hreadyout_out) else $error("bus wait inserted");
  a_resp_okay: assert property (!hresp_out) else $error("bus error response");
  a_halt_stop: assert property (s_go ##0 ir_r == 12'h000 |-> ##[1:12] !run_out)
    else $error("halt left run set");
  a_run_src: assert property ($fell(run_out) |-> ir_r == 12'h000 || |ctl_d)
    else $error("run dropped without halt");
  a_mode_src: assert property ($changed(mode_out) |-> ir_r == 12'h002 || |ctl_d)
    else $error("mode moved without switch");
  a_save_src: assert property ($fell(save_pc_out) |-> ir_r == 12'h006 || |ctl_d)
    else $error("save flag dropped wrongly");
  a_relay_src: assert property ($changed(relay_out) |-> ir_r == 12'h00C)
    else $error("relays moved without load");
  a_preset_one: assert property (io_preset_out |=> !io_preset_out)
    else $error("preset pulse too long");
  a_preset_src: assert property ($rose(io_preset_out) |-> ir_r == 12'h004)
    else $error("preset without set funcs");
  a_skip_src: assert property ($rose(skip_out) |-> ir_r[11:6] == 6'h04)
    else $error("skip set outside skip group");
  a_skip_clear: assert property (s_go ##0 skip_out |-> ##[1:6] !skip_out)
    else $error("skip not cleared on start");
endmodule : mss_exec_chk
bind mss_exec mss_exec_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .run_out(run_out), .mode_out(mode_out), .skip_out(skip_out),
  .save_pc_out(save_pc_out), .io_preset_out(io_preset_out), .relay_out(relay_out));
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import mss_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [5:0]  sense = 6'h00;
  logic [15:0] ext = 16'h0000;
  logic        ovf = 1'b0;
  wire  [31:0] hrdata;
  wire         hready, hresp, run, mode, skip, save_pc, preset;
  wire  [5:0]  relay;
  int          err_total = 0;
  int          n_compared = 0;
  int          n_pre = 0;
  mss_exec uut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .sense_sw_in(sense), .ext_level_in(ext), .overflow_in(ovf), .run_out(run),
    .mode_out(mode), .skip_out(skip), .save_pc_out(save_pc), .io_preset_out(preset),
    .relay_out(relay));
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  // count preset pulses, one per set-funcs with acc bit 7
  always @(posedge clk) if (preset === 1'b1) n_pre++;
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // single word transfer; each phase is held until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask : rd
  // load state, run one instruction, poll busy, then check skip, acc, mq and control
  task automatic row(input logic [11:0] ir, a, q, input logic [3:0] c,
                     input logic [11:0] ea, eq, input logic [3:0] ec, input logic es);
    logic [31:0] r;
    int          n;
    n = 0;
    wr(`MSS_A_CTRL, {28'h000_0000, c});
    wr(`MSS_A_IR, {20'h0_0000, ir});
    wr(`MSS_A_ACC, {20'h0_0000, a});
    wr(`MSS_A_MQ, {20'h0_0000, q});
    wr(`MSS_A_STAT, 32'h0000_0001);
    do begin
      rd(`MSS_A_STAT, r);
      n++;
    end while (r[1] !== 1'b0 && n < 40);
    `CHK(r[1], 1'b0)
    `CHK(r[2], es)
    `CHK(skip, es)
    rd(`MSS_A_ACC, r);
    `CHK(r[11:0], ea)
    rd(`MSS_A_MQ, r);
    `CHK(r[11:0], eq)
    rd(`MSS_A_CTRL, r);
    `CHK(r[3:0], ec)
    `CHK({save_pc, mode, run}, ec[2:0])
    $display("op %h done", ir);
  endtask : row
  // skip rows leave acc, mq and control unchanged
  task automatic always_skip(input logic [11:0] ir, a, q, input logic [3:0] c, input logic es);
    row(ir, a, q, c, a, q, c, es);
  endtask : always_skip
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk);
    rst   <= 1'b0;
    sense <= 6'h08;
    ext   <= 16'h0020;
    ovf   <= 1'b1;
    row(12'h00F, 12'h29C, 12'h123, 4'h1, 12'hD63, 12'h123, 4'h1, 1'b0);
    row(12'h005, 12'h29C, 12'hFFF, 4'h1, 12'h7FF, 12'hFFF, 4'h1, 1'b0);
    row(12'h009, 12'hB6D, 12'h249, 4'h9, 12'h000, 12'h000, 4'h1, 1'b0);
    row(12'h000, 12'h001, 12'h002, 4'h1, 12'h001, 12'h002, 4'h0, 1'b0);
    row(12'h002, 12'h001, 12'h002, 4'h1, 12'h001, 12'h002, 4'h3, 1'b0);
    row(12'h006, 12'h001, 12'h002, 4'h5, 12'h001, 12'h002, 4'h1, 1'b0);
    row(12'h00C, 12'h02A, 12'h000, 4'h1, 12'h02A, 12'h000, 4'h1, 1'b0);
    `CHK(relay, 6'h2A)
    row(12'h00D, 12'hFC0, 12'h000, 4'h1, 12'hFEA, 12'h000, 4'h1, 1'b0);
    row(12'h004, 12'h3E0, 12'h000, 4'h1, 12'h3E0, 12'h000, 4'h1, 1'b0);
    rd(`MSS_A_STAT, r);
    `CHK(r[13:3], 11'h55F)
    row(12'h014, 12'hFFF, 12'h000, 4'h1, 12'h3E0, 12'h000, 4'h1, 1'b0);
    row(12'h004, 12'h010, 12'h000, 4'h1, 12'h010, 12'h000, 4'h1, 1'b0);
    `CHK(n_pre, 1)
    row(12'h014, 12'hFFF, 12'h000, 4'h1, 12'h000, 12'h000, 4'h1, 1'b0);
    row(12'h0C3, 12'h007, 12'h005, 4'h1, 12'hA00, 12'hE00, 4'h1, 1'b0);
    row(12'h0D1, 12'h001, 12'h001, 4'h1, 12'h000, 12'h800, 4'h9, 1'b0);
    row(12'h0E2, 12'h800, 12'h000, 4'h9, 12'hE00, 12'h000, 4'h9, 1'b0);
    row(12'h0F1, 12'h001, 12'h000, 4'h1, 12'h000, 12'h800, 4'h9, 1'b0);
    row(12'h0A1, 12'h801, 12'h555, 4'h1, 12'h003, 12'h555, 4'h1, 1'b0);
    row(12'h0B2, 12'h800, 12'h555, 4'h9, 12'h003, 12'h555, 4'h1, 1'b0);
    row(12'h0AF, 12'h801, 12'h555, 4'h1, 12'h00C, 12'h555, 4'h1, 1'b0);
    row(12'h0A0, 12'h29C, 12'h555, 4'h9, 12'h29C, 12'h555, 4'h9, 1'b0);
    row(12'h0C0, 12'h29C, 12'h555, 4'h1, 12'h29C, 12'h555, 4'h1, 1'b0);
    always_skip(12'h12E, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h13E, 12'h000, 12'h000, 4'h1, 1'b0);
    always_skip(12'h129, 12'h7FF, 12'h000, 4'h1, 1'b1);
    always_skip(12'h129, 12'h800, 12'h000, 4'h1, 1'b0);
    always_skip(12'h128, 12'hFFF, 12'h000, 4'h1, 1'b1);
    always_skip(12'h128, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h128, 12'h001, 12'h000, 4'h1, 1'b0);
    always_skip(12'h12A, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h12A, 12'h000, 12'h000, 4'h9, 1'b0);
    always_skip(12'h12C, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h13C, 12'h000, 12'h000, 4'h1, 1'b0);
    always_skip(12'h12D, 12'h000, 12'hFFE, 4'h1, 1'b1);
    always_skip(12'h12D, 12'h000, 12'h001, 4'h1, 1'b0);
    always_skip(12'h123, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h122, 12'h000, 12'h000, 4'h1, 1'b0);
    always_skip(12'h105, 12'h000, 12'h000, 4'h1, 1'b1);
    always_skip(12'h115, 12'h000, 12'h000, 4'h1, 1'b0);
    // a write to an unused offset must not touch the accumulator
    wr(32'h0000_0040, 32'h0000_0FFF);
    rd(`MSS_A_ACC, r);
    `CHK(r[11:0], 12'h000)
    // with run cleared a start must be ignored
    wr(`MSS_A_CTRL, 32'h0000_0000);
    wr(`MSS_A_IR, 32'h0000_000F);
    wr(`MSS_A_STAT, 32'h0000_0001);
    rd(`MSS_A_STAT, r);
    `CHK(r[1], 1'b0)
    rd(`MSS_A_ACC, r);
    `CHK(r[11:0], 12'h000)
    $display("halted start test done");
    final_report;
  end
  // hang guard, far beyond the 1200 or so cycles the rows need
  initial begin
    #500000;
    err_total++;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
